/* File: verilog/bmbe_exec.sv */
// execution engine for bit clear, set, or and bit-test branches
`timescale 1ns/100ps
`default_nettype none
`include "bmbe_map.svh"
module bmbe_exec (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// instruction from the fetch unit, bytes already past the opcode
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  operand,
	input  wire logic [7:0]  third,
	input  wire logic [15:0] program_counter,
	// register file read port, data valid the cycle after the address
	output logic      [7:0]  rf_raddr,
	input  wire logic [7:0]  rf_rdata,
	// register file write port
	output logic             rf_we,
	output logic      [7:0]  rf_waddr,
	output logic      [7:0]  rf_wdata,
	// flags in and out
	input  wire logic [7:0]  flags_in,
	output logic             flags_we,
	output logic      [7:0]  flags_out,
	// program counter update
	output logic             pc_we,
	output logic      [15:0] pc_next,
	// status
	output logic             busy,
	output logic             done,
	output logic             illegal
);
	// complete block state
	typedef struct packed {
		bmbe_pkg::bmbe_state_t st;
		bmbe_pkg::bmbe_op_t    op;
		logic [3:0]            cnt;
		logic [7:0]            raddr;
		logic [7:0]            waddr;
		logic [7:0]            xval;
		logic                  xok;
		logic [2:0]            bidx;
		logic [7:0]            disp;
		logic [15:0]           pc;
		logic                  we;
		logic [7:0]            wdata;
		logic                  fwe;
		logic [7:0]            fout;
		logic                  pwe;
		logic [15:0]           pnext;
		logic                  busy;
		logic                  done;
		logic                  ill;
	} bmbe_state_s_t;

	bmbe_state_s_t      r;
	bmbe_state_s_t      next_r;
	bmbe_pkg::bmbe_op_t dec_op;
	logic [1:0]         dec_len;
	logic [3:0]         dec_cyc;

	// working register number maps into the fixed working bank at 8'hc0
	function automatic logic [7:0] wreg(input logic [3:0] n);
		wreg = `BMBE_WREG_BASE | {4'h0, n};
	endfunction

	// one-hot bit mask for a 3-bit index
	function automatic logic [7:0] bmask(input logic [2:0] b);
		bmask = 8'h01 << b;
	endfunction

	bmbe_decode u_decode (
		.opcode  (opcode),
		.operand (operand),
		.op      (dec_op),
		.length  (dec_len),
		.cycles  (dec_cyc)
	);

	// next-state logic; every instruction runs for its full cycle count so
	// the core's timing matches the documented figures exactly
	always_comb begin
		logic [7:0] src;
		// a bit-or naming one register twice reads it once; that read is the source
		src         = r.xok ? r.xval : rf_rdata;
		next_r      = r;
		next_r.we   = 1'b0;
		next_r.fwe  = 1'b0;
		next_r.pwe  = 1'b0;
		next_r.done = 1'b0;
		next_r.ill  = 1'b0;
		unique case (r.st)
			bmbe_pkg::BMBE_IDLE: begin
				if (start) begin
					next_r.op   = dec_op;
					next_r.cnt  = dec_cyc - 4'h1;
					next_r.bidx = operand[`BMBE_BIT_MSB:`BMBE_BIT_LSB];
					next_r.disp = third;
					next_r.pc   = program_counter;
					next_r.xval = 8'h00;
					next_r.xok  = 1'b0;
					next_r.raddr = wreg(operand[`BMBE_REG_MSB:`BMBE_REG_LSB]);
					next_r.waddr = wreg(operand[`BMBE_REG_MSB:`BMBE_REG_LSB]);
					if (dec_op == bmbe_pkg::BMBE_OP_OR0) begin
						// destination is working reg; third byte names the source
						next_r.raddr = third;
					end
					if (dec_op == bmbe_pkg::BMBE_OP_ORB) begin
						next_r.waddr = third;
					end
					if (dec_op == bmbe_pkg::BMBE_OP_NONE) begin
						next_r.ill  = 1'b1;
						next_r.done = 1'b1;
					end else begin
						next_r.busy = 1'b1;
						next_r.st   = bmbe_pkg::BMBE_READ;
					end
				end
			end
			bmbe_pkg::BMBE_READ: begin
				// first read: the operand whose bit is tested or combined
				next_r.cnt = r.cnt - 4'h1;
				next_r.st  = bmbe_pkg::BMBE_WAIT;
			end
			bmbe_pkg::BMBE_WAIT: begin
				next_r.cnt = r.cnt - 4'h1;
				if (r.op == bmbe_pkg::BMBE_OP_OR0 || r.op == bmbe_pkg::BMBE_OP_ORB) begin
					// capture one operand, then read the one to be written
					if (r.raddr != r.waddr) begin
						next_r.xval  = rf_rdata;
						next_r.xok   = 1'b1;
						next_r.raddr = r.waddr;
						next_r.st    = bmbe_pkg::BMBE_READ;
						// collapse to write when both addresses now match
						next_r.waddr = r.waddr;
					end else begin
						next_r.st = bmbe_pkg::BMBE_WRITE;
					end
				end else begin
					next_r.st = bmbe_pkg::BMBE_WRITE;
				end
				if (r.raddr == r.waddr) begin
					next_r.st = bmbe_pkg::BMBE_WRITE;
					unique case (r.op)
						bmbe_pkg::BMBE_OP_CLR: begin
							next_r.we    = 1'b1;
							next_r.wdata = rf_rdata & ~bmask(r.bidx);
						end
						bmbe_pkg::BMBE_OP_SET: begin
							next_r.we    = 1'b1;
							next_r.wdata = rf_rdata | bmask(r.bidx);
						end
						// src bit b into dst bit 0
						bmbe_pkg::BMBE_OP_OR0: begin
							next_r.we    = 1'b1;
							next_r.wdata = rf_rdata | {7'h00, src[r.bidx]};
							// zero from result bit, sign cleared
							next_r.fwe   = 1'b1;
							next_r.fout  = flags_in;
							next_r.fout[`BMBE_FLAG_Z] = ~(rf_rdata[0] | src[r.bidx]);
							next_r.fout[`BMBE_FLAG_S] = 1'b0;
						end
						// working bit 0 into dst bit b
						bmbe_pkg::BMBE_OP_ORB: begin
							next_r.we    = 1'b1;
							next_r.wdata = rf_rdata | (src[0] ? bmask(r.bidx) : 8'h00);
							// zero from result bit, sign cleared
							next_r.fwe   = 1'b1;
							next_r.fout  = flags_in;
							next_r.fout[`BMBE_FLAG_Z] = ~(rf_rdata[r.bidx] | src[0]);
							next_r.fout[`BMBE_FLAG_S] = 1'b0;
						end
						bmbe_pkg::BMBE_OP_BRF: begin
							next_r.pwe = ~rf_rdata[r.bidx];
						end
						bmbe_pkg::BMBE_OP_BRT: begin
							next_r.pwe = rf_rdata[r.bidx];
						end
						default: begin
							next_r.we = 1'b0;
						end
					endcase
					next_r.pnext = r.pc + {{8{r.disp[7]}}, r.disp};
				end
			end
			bmbe_pkg::BMBE_WRITE: begin
				// pad out to the instruction's documented cycle count
				next_r.cnt = r.cnt - 4'h1;
				if (r.cnt <= 4'h1) begin
					next_r.st = bmbe_pkg::BMBE_DONE;
				end
			end
			bmbe_pkg::BMBE_DONE: begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.st   = bmbe_pkg::BMBE_IDLE;
			end
		endcase
	end

	// single state register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{st: bmbe_pkg::BMBE_IDLE, op: bmbe_pkg::BMBE_OP_NONE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the state flops
	assign rf_raddr  = r.raddr;
	assign rf_we     = r.we;
	assign rf_waddr  = r.waddr;
	assign rf_wdata  = r.wdata;
	assign flags_we  = r.fwe;
	assign flags_out = r.fout;
	assign pc_we     = r.pwe;
	assign pc_next   = r.pnext;
	assign busy      = r.busy;
	assign done      = r.done;
	assign illegal   = r.ill;
endmodule // bmbe_exec
`default_nettype wire

/* File: inc/bmbe_map.svh */
// constants for the bit manipulation and branch executor
`ifndef BMBE_MAP_SVH
`define BMBE_MAP_SVH
`define BMBE_OPC_BIT_CLRSET 8'h77
`define BMBE_OPC_BIT_OR     8'h07
`define BMBE_OPC_BIT_BRANCH 8'h37
`define BMBE_LEN_BIT_CLRSET 2'h2
`define BMBE_LEN_BIT_OR     2'h3
`define BMBE_LEN_BIT_BRANCH 2'h3
`define BMBE_CYC_BIT_CLRSET 4'h4
`define BMBE_CYC_BIT_OR     4'h6
`define BMBE_CYC_BIT_BRANCH 4'ha
`define BMBE_REG_MSB        7
`define BMBE_REG_LSB        4
`define BMBE_BIT_MSB        3
`define BMBE_BIT_LSB        1
`define BMBE_SEL_POS        0
`define BMBE_FLAG_Z         6
`define BMBE_FLAG_S         5
`define BMBE_WREG_BASE      8'hc0
`endif

/* File: inc/bmbe_pkg.sv */
// types for the bit manipulation and branch executor
package bmbe_pkg;
	typedef enum logic [4:0] {
		BMBE_IDLE  = 5'b00001,
		BMBE_READ  = 5'b00010,
		BMBE_WAIT  = 5'b00100,
		BMBE_WRITE = 5'b01000,
		BMBE_DONE  = 5'b10000
	} bmbe_state_t;

	typedef enum logic [2:0] {
		BMBE_OP_CLR  = 3'h0,
		BMBE_OP_SET  = 3'h1,
		BMBE_OP_OR0  = 3'h2,
		BMBE_OP_ORB  = 3'h3,
		BMBE_OP_BRF  = 3'h4,
		BMBE_OP_BRT  = 3'h5,
		BMBE_OP_NONE = 3'h7
	} bmbe_op_t;
endpackage : bmbe_pkg

/* File: verilog/bmbe_decode.sv */
// decoder from opcode and second byte to operation, length and cycle count
`timescale 1ns/100ps
`default_nettype none
`include "bmbe_map.svh"
module bmbe_decode (
	// instruction bytes
	input  wire logic [7:0]       opcode,
	input  wire logic [7:0]       operand,
	// decoded result
	output var  bmbe_pkg::bmbe_op_t op,
	output logic      [1:0]       length,
	output logic      [3:0]       cycles
);
	logic sel;

	// selector sits in the lsb of the second byte
	// operand byte layout
	assign sel = operand[`BMBE_SEL_POS];

	// opcode decode; unknown opcodes give BMBE_OP_NONE so the core flags them illegal
	always_comb begin
		op     = bmbe_pkg::BMBE_OP_NONE;
		length = 2'h0;
		cycles = 4'h0;
		unique case (opcode)
			`BMBE_OPC_BIT_CLRSET: begin
				op     = sel ? bmbe_pkg::BMBE_OP_SET : bmbe_pkg::BMBE_OP_CLR;
				length = `BMBE_LEN_BIT_CLRSET;
				cycles = `BMBE_CYC_BIT_CLRSET;
			end
			`BMBE_OPC_BIT_OR: begin
				op     = sel ? bmbe_pkg::BMBE_OP_ORB : bmbe_pkg::BMBE_OP_OR0;
				length = `BMBE_LEN_BIT_OR;
				cycles = `BMBE_CYC_BIT_OR;
			end
			`BMBE_OPC_BIT_BRANCH: begin
				op     = sel ? bmbe_pkg::BMBE_OP_BRT : bmbe_pkg::BMBE_OP_BRF;
				length = `BMBE_LEN_BIT_BRANCH;
				cycles = `BMBE_CYC_BIT_BRANCH;
			end
			default: begin
				op     = bmbe_pkg::BMBE_OP_NONE;
				length = 2'h0;
				cycles = 4'h0;
			end
		endcase
	end
endmodule // bmbe_decode
`default_nettype wire

/* File: bench/bmbe_exec_monitor.sv */
// port checker for the bit manipulation and branch executor
`timescale 1ns/100ps
`default_nettype none
module bmbe_exec_monitor (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// instruction in
	input wire logic        start,
	input wire logic [7:0]  opcode,
	input wire logic [7:0]  operand,
	input wire logic [7:0]  third,
	input wire logic [15:0] program_counter,
	// register write and flags
	input wire logic        rf_we,
	input wire logic [7:0]  rf_waddr,
	input wire logic [7:0]  rf_wdata,
	input wire logic [7:0]  flags_in,
	input wire logic        flags_we,
	input wire logic [7:0]  flags_out,
	// branch and status
	input wire logic        pc_we,
	input wire logic [15:0] pc_next,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        illegal
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// a take only counts in idle, so a start held while busy is ignored
	sequence s_take(logic [7:0] opc);
		start && !busy && !done && opcode == opc;
	endsequence
	sequence s_no_flag_pc;
		!flags_we && !pc_we;
	endsequence
	// checks rely on the bench holding the instruction bytes until done
	AST_CLRSET_QUIET: assert property (s_take(8'h77) |=> s_no_flag_pc [*4])
		else $error("flags or pc touched by bit clear or set");
	AST_BR_QUIET: assert property (s_take(8'h37) |=> (!flags_we && !rf_we) [*8])
		else $error("branch wrote flags or a register");
	AST_BR_BUSY: assert property (s_take(8'h37) |=> busy [*3])
		else $error("branch did not hold busy");
	AST_OR_DONE: assert property (s_take(8'h07) |-> ##[2:12] done)
		else $error("bit or did not finish in time");
	AST_OR_FLAGS: assert property (flags_we |-> rf_we && !flags_out[5]
		&& flags_out[6] == !rf_wdata[operand[0] ? operand[3:1] : 3'h0])
		else $error("zero or sign flag wrong after bit or");
	AST_OR_KEEP: assert property (flags_we |-> flags_out[7] == flags_in[7]
		&& flags_out[4:0] == flags_in[4:0])
		else $error("untouched flags changed by bit or");
	AST_PC_TARGET: assert property (pc_we |->
		pc_next == program_counter + {{8{third[7]}}, third})
		else $error("branch target wrong");
	AST_PC_ONLY: assert property (pc_we |-> opcode == 8'h37 && !flags_we)
		else $error("pc written outside a branch");
	AST_CLR_ADDR: assert property (rf_we && opcode == 8'h77 |->
		rf_waddr == {4'hc, operand[7:4]})
		else $error("bit clear or set wrote the wrong register");
	AST_ILLEGAL: assert property (start && !busy && !done && opcode != 8'h77
		&& opcode != 8'h07 && opcode != 8'h37 |=> illegal && done && !rf_we)
		else $error("unknown opcode not refused");
endmodule // bmbe_exec_monitor
bind bmbe_exec bmbe_exec_monitor u_mon (.sys_clk(sys_clk), .arst_n(arst_n), .start(start),
	.opcode(opcode), .operand(operand), .third(third), .program_counter(program_counter),
	.rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .flags_in(flags_in),
	.flags_we(flags_we), .flags_out(flags_out), .pc_we(pc_we), .pc_next(pc_next),
	.busy(busy), .done(done), .illegal(illegal));
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the bit manipulation and branch executor
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        sys_clk, arst_n, start, rf_we, flags_we, pc_we, busy, done, illegal;
	logic        pc_hit, ill_hit;
	logic [7:0]  opcode, operand, third, rf_raddr, rf_rdata, rf_waddr, rf_wdata;
	logic [7:0]  flags_in = 8'hbf; // sign set, zero clear, others set to catch stray writes
	logic [7:0]  flags_out;
	logic [15:0] program_counter, pc_next;
	logic [15:0] pc_got = 16'h0000;
	logic [7:0]  mem [256];
	logic [7:0]  br_opr [4] = '{8'h12, 8'h15, 8'h14, 8'h13};
	logic [7:0]  br_disp [4] = '{8'h80, 8'h7f, 8'h01, 8'h01};
	logic [15:0] br_exp [4] = '{16'h0f80, 16'h107f, 16'hffff, 16'hffff};
	int          n_fail, check_count, tests, i, cyc;
	bmbe_exec dut (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .opcode(opcode),
		.operand(operand), .third(third), .program_counter(program_counter),
		.rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr),
		.rf_wdata(rf_wdata), .flags_in(flags_in), .flags_we(flags_we),
		.flags_out(flags_out), .pc_we(pc_we), .pc_next(pc_next), .busy(busy),
		.done(done), .illegal(illegal));
	// register file with one cycle of read latency, flags register, pulse capture
	always @(posedge sys_clk) begin
		rf_rdata <= mem[rf_raddr];
		if (rf_we === 1'b1) mem[rf_waddr] <= rf_wdata;
		if (flags_we === 1'b1) flags_in <= flags_out;
		// a new instruction clears the pulse captures of the last one
		if (start === 1'b1) pc_hit <= 1'b0;
		if (start === 1'b1) ill_hit <= 1'b0;
		if (pc_we === 1'b1) pc_got <= pc_next;
		if (pc_we === 1'b1) pc_hit <= 1'b1;
		if (illegal === 1'b1) ill_hit <= 1'b1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// bytes stay on the inputs until the next instruction, as the monitor checks need them
	task automatic run(input logic [7:0] opc, input logic [7:0] opr, input logic [7:0] thd);
		int k;
		@(posedge sys_clk);
		start <= 1'b1;
		opcode <= opc;
		operand <= opr;
		third <= thd;
		@(posedge sys_clk);
		start <= 1'b0;
		for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge sys_clk);
		if (done !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
		cyc = k;
		#1; // let the capture of this edge land before comparing
		tests++;
		$display("test %0d done", tests);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{arst_n, start, opcode, operand, third} = '0;
		{n_fail, check_count, tests, cyc} = '0;
		program_counter = 16'h1000;
		for (i = 0; i < 256; i++) mem[i] = 8'h00;
		mem[8'hc1] = 8'h07;
		mem[8'h01] = 8'h03;
		mem[8'hc3] = 8'hfe;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		run(8'h77, 8'h12, 8'h00);
		chk(mem[8'hc1], 8'h05);
		// edges from take to done: the instruction's cycle count plus the done cycle
		chk(16'(cyc), 16'd5);
		run(8'h77, 8'h17, 8'h00);
		chk(mem[8'hc1], 8'h0d);
		chk(16'(cyc), 16'd5);
		run(8'h77, 8'hff, 8'h00);
		chk(mem[8'hcf], 8'h80);
		chk(flags_in, 8'hbf);
		run(8'h07, 8'h22, 8'h01);
		chk(mem[8'hc2], 8'h01);
		chk(16'(cyc), 16'd7);
		chk(flags_in, 8'h9f);
		run(8'h07, 8'h34, 8'h01);
		chk(mem[8'hc3], 8'hfe);
		chk(flags_in, 8'hdf);
		run(8'h07, 8'h15, 8'h01);
		chk(mem[8'h01], 8'h07);
		chk(mem[8'hc1], 8'h0d);
		chk(flags_in, 8'h9f);
		// both polarities, taken and not, with the extreme displacements
		for (i = 0; i < 4; i++) begin
			run(8'h37, br_opr[i], br_disp[i]);
			chk(pc_hit === 1'b1 ? pc_got : 16'hffff, br_exp[i]);
			chk(flags_in, 8'h9f);
			chk(16'(cyc), 16'd11);
		end
		run(8'h17, 8'h12, 8'h00);
		chk(ill_hit, 1'b1);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
